//--- rtl/sd_adc_ctrl_pkg.sv
/*
  Constants, field layout, timing and state types for the sigma-delta converter
  sequencer and its serial register port.
  Assumes a single 25 MHz core clock; the converter timing is scaled from the
  nominal fast core clock frequency.
*/
package sd_adc_ctrl_pkg;

  // Clock figures
  localparam longint CLK_HZ = 25_000_000;
  localparam longint FAST_CORE_CLOCK_HZ = 4_915_200;
  localparam longint WORD_RATE_DIV = 448;

  // Decimation ratio per rate code
  localparam int unsigned DECIM_RATIO [8] = '{1096, 274, 220, 183, 55, 46, 27, 23};

  // Core clocks per conversion cycle
  function automatic logic [31:0] cyclesFor(input int unsigned ratio);
    longint c;
    c = (WORD_RATE_DIV * longint'(ratio) * CLK_HZ) / FAST_CORE_CLOCK_HZ;
    if (c < 1)
    begin
      c = 1;
    end
    return c[31:0];
  endfunction

  localparam logic [31:0] CONV_CYCLES_DEF [8] = '{
    cyclesFor(DECIM_RATIO[0]), cyclesFor(DECIM_RATIO[1]), cyclesFor(DECIM_RATIO[2]), cyclesFor(DECIM_RATIO[3]),
    cyclesFor(DECIM_RATIO[4]), cyclesFor(DECIM_RATIO[5]), cyclesFor(DECIM_RATIO[6]), cyclesFor(DECIM_RATIO[7])};

  // Index of the last conversion cycle before a valid result or end of a calibration phase
  localparam logic [1:0] LAST_SETTLE_CYCLE = 2'h3;

  // converter_config fields
  localparam int CFG_POWER = 15;
  localparam int CFG_GO = 14;
  localparam int CFG_BIPOLAR = 13;
  localparam int CFG_POLARITY = 12;
  localparam int CFG_CONTINUOUS_EN = 11;
  localparam int CFG_REF = 10;
  localparam int CFG_GAIN_LSB = 8;
  localparam int CFG_RATE_LSB = 5;
  localparam int CFG_MODE_LSB = 2;
  localparam logic [15:0] CFG_WRITE_MASK = 16'hFFFC;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0] MUX_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Serial command byte
  localparam logic [4:0] ADDR_CONFIG = 5'h00;
  localparam logic [4:0] ADDR_SELECT = 5'h01;
  localparam logic [4:0] ADDR_DATA = 5'h02;
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;
  localparam logic [5:0] CFG_LAST_BIT = 6'h17;
  localparam logic [5:0] SEL_LAST_BIT = 6'h0F;
  localparam logic [5:0] BIT_CNT_MAX = 6'h3F;

  // Input selection code for an open switch
  localparam logic [3:0] INPUT_OPEN = 4'hF;

  // Mode codes
  localparam logic [2:0] MODE_SYS_OFFSET = 3'h1;
  localparam logic [2:0] MODE_SYS_GAIN = 3'h2;
  localparam logic [2:0] MODE_SELF_OFFSET = 3'h5;
  localparam logic [2:0] MODE_SELF_GAIN = 3'h6;
  localparam logic [2:0] MODE_SELF_BOTH = 3'h7;
  localparam logic [2:0] MODE_NORMAL = 3'h0;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_CAL_OFF, SEQ_CAL_GAIN} seq_e;

endpackage

//--- rtl/sd_adc_ctrl.sv
/*
  Conversion sequencer and serial register port of a 16-bit sigma-delta converter.
  Assumes async serial pins and an offset-binary filter result on clk.
*/
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] Power bit one powers converter up
// [R2] Config go bit clears filter, starts after bit 16
// [R3] First result after four conversion cycles
// [R4] Continuous results each one cycle afterwards
// [R5] Single mode: one conversion, then hold result
// [R6] Continuous mode runs until continuous_en or power cleared
// [R7] Go bit self-clears and done sets after four
// [R8] Config write without go is staged, except power and continuous_en
// [R9] Bipolar selects two's complement, else unsigned
// [R10] Polarity bit swaps positive and negative paths
// [R11] Clearing continuous_en stops, keeps result, drops filter
// [R12] Setting continuous_en alone never restarts converter
// [R13] Reference select: pin at zero, supply at one
// [R14] Gain codes select gains 1, 2, 4, 8
// [R15] Rate codes select eight decimation ratios
// [R16] Word rate is clock over 448 times ratio
// [R17] Mode field decodes calibrations and normal conversion
// [R18] Calibration end clears mode, sets done, signals
// [R19] Combined calibration: offset first, then gain
// [R20] Idle after power-on or calibration until started
// [R21] Host gain-calibrates after offset is settled
// [R22] Select write with flag starts after data
// [R23] Select read with flag starts after address
// [R24] Select write without flag changes inputs only
// [R25] Power off: idle, ignore starts, keep data
module sd_adc_ctrl
  import sd_adc_ctrl_pkg::*;
#(
  parameter logic [31:0] CONV_CYCLES [8] = CONV_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial port
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic doutOeN,
  // Filter result and event mask pin
  input wire logic [15:0] filterData,
  input wire logic convDoneMask,
  // Analog front end controls
  output logic convPowerEn,
  output logic filterClear,
  output logic [3:0] posInputSel,
  output logic [3:0] negInputSel,
  output logic polaritySwap,
  output logic bipolarSel,
  output logic referenceSel,
  output logic [1:0] gainSel,
  output logic [2:0] rateSel,
  output logic [2:0] calMode,
  output logic convBusy,
  // Status
  output logic convDoneFlag,
  output logic resultReadyOut
);

  typedef struct packed {
    logic sclkS1;
    logic sclkS2;
    logic sclkPrev;
    logic csS1;
    logic csS2;
    logic dinS1;
    logic dinS2;
    logic maskS1;
    logic maskS2;
    logic [5:0] bitCnt;
    logic frameBad;
    logic [7:0] cmd;
    logic [15:0] inShift;
    logic [15:0] outShift;
    logic dout;
    logic doutOeN;
    logic [15:0] cfg;
    logic [15:0] staged;
    logic [7:0] sel;
    seq_e seq;
    logic [31:0] cycCnt;
    logic [1:0] convNum;
    logic runCont;
    logic [2:0] activeMode;
    logic [15:0] data;
    logic doneFlag;
    logic filterClear;
    logic [3:0] posOut;
    logic [3:0] negOut;
    logic readyOut;
    logic busy;
  } state_s;
  state_s st_r, st_nxt;
  logic sclkRise, sclkFall, startReq, cycEnd, phaseEnd, dataLoad, calEnd, stagedWrite;
  logic [7:0] cmdByte;
  logic [15:0] dataWord, newCfg;
  ////////////////////////////////////////////////////////////////////////////////
  // Mode to first sequencer state
  function automatic seq_e firstState(input logic [2:0] mode);
    case (mode) // [R17]
      MODE_SYS_OFFSET, MODE_SELF_OFFSET, MODE_SELF_BOTH: return SEQ_CAL_OFF;
      MODE_SYS_GAIN, MODE_SELF_GAIN: return SEQ_CAL_GAIN;
      default: return SEQ_CONV;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    startReq = 1'b0;
    newCfg = st_r.cfg;
    cycEnd = 1'b0;
    phaseEnd = 1'b0;
    dataLoad = 1'b0;
    calEnd = 1'b0;
    stagedWrite = 1'b0;
    cmdByte = {st_r.cmd[6:0], st_r.dinS2};
    dataWord = {st_r.inShift[14:0], st_r.dinS2};
    // Pin synchronisers
    st_nxt.sclkS1 = sclk;
    st_nxt.sclkS2 = st_r.sclkS1;
    st_nxt.sclkPrev = st_r.sclkS2;
    st_nxt.csS1 = csN;
    st_nxt.csS2 = st_r.csS1;
    st_nxt.dinS1 = din;
    st_nxt.dinS2 = st_r.dinS1;
    st_nxt.maskS1 = convDoneMask;
    st_nxt.maskS2 = st_r.maskS1;
    st_nxt.filterClear = 1'b0;
    sclkRise = st_r.sclkS2 & ~st_r.sclkPrev;
    sclkFall = ~st_r.sclkS2 & st_r.sclkPrev;
    // Serial frame
    if (st_r.csS2)
    begin
      st_nxt.bitCnt = 6'h00;
      st_nxt.frameBad = 1'b0;
      st_nxt.dout = 1'b0;
      st_nxt.doutOeN = 1'b1;
      st_nxt.outShift = 16'h0000;
    end
    else
    begin
      st_nxt.doutOeN = 1'b0;
      if (sclkFall)
      begin
        st_nxt.dout = st_r.outShift[15];
        st_nxt.outShift = {st_r.outShift[14:0], 1'b0};
      end
      if (sclkRise && !st_r.frameBad && st_r.bitCnt != BIT_CNT_MAX)
      begin
        st_nxt.bitCnt = st_r.bitCnt + 6'h01;
        if (st_r.bitCnt <= CMD_LAST_BIT)
          st_nxt.cmd = cmdByte;
        else
          st_nxt.inShift = dataWord;
        if (st_r.bitCnt == 6'h00 && !st_r.dinS2)
          st_nxt.frameBad = 1'b1;
        if (st_r.bitCnt == CMD_LAST_BIT && cmdByte[6])
        begin
          case (cmdByte[5:1])
            ADDR_CONFIG: st_nxt.outShift = st_r.cfg;
            ADDR_SELECT: st_nxt.outShift = {st_r.sel, 8'h00};
            ADDR_DATA:
            begin
              st_nxt.outShift = st_r.data;
              st_nxt.doneFlag = 1'b0;
            end
            default: st_nxt.outShift = 16'h0000;
          endcase
          if (cmdByte[5:1] == ADDR_SELECT && cmdByte[0])
          begin
            newCfg = st_r.staged; // [R23]
            startReq = 1'b1;
          end
        end
        if (!st_r.cmd[6] && st_r.cmd[5:1] == ADDR_CONFIG && st_r.bitCnt == CFG_LAST_BIT)
        begin
          st_nxt.staged = dataWord & CFG_WRITE_MASK;
          st_nxt.staged[CFG_GO] = 1'b0;
          if (dataWord[CFG_GO])
          begin
            newCfg = dataWord & CFG_WRITE_MASK; // [R2]
            startReq = 1'b1;
          end
          else
          begin
            // Settings wait for a start; power and continuous_en act now
            stagedWrite = 1'b1; // [R8]
            st_nxt.cfg[CFG_POWER] = dataWord[CFG_POWER]; // [R1]
            st_nxt.cfg[CFG_CONTINUOUS_EN] = dataWord[CFG_CONTINUOUS_EN]; // [R12]
          end
        end
        if (!st_r.cmd[6] && st_r.cmd[5:1] == ADDR_SELECT && st_r.bitCnt == SEL_LAST_BIT)
        begin
          st_nxt.sel = dataWord[7:0]; // [R24]
          if (st_r.cmd[0])
          begin
            newCfg = st_r.staged; // [R22]
            startReq = 1'b1;
          end
        end
      end
    end
    // Sequencer
    if (st_r.seq != SEQ_IDLE)
    begin
      cycEnd = st_r.cycCnt >= CONV_CYCLES[st_r.cfg[CFG_RATE_LSB +: 3]] - 32'h1; // [R15] [R16]
      st_nxt.cycCnt = cycEnd ? 32'h0 : st_r.cycCnt + 32'h1;
      if (cycEnd)
      begin
        if (st_r.convNum != LAST_SETTLE_CYCLE)
          st_nxt.convNum = st_r.convNum + 2'h1; // [R3]
        else
          phaseEnd = 1'b1; // [R4]
      end
    end
    case (st_r.seq)
      SEQ_IDLE: ;
      SEQ_CONV:
      begin
        if (st_r.runCont && !st_r.cfg[CFG_CONTINUOUS_EN])
        begin
          st_nxt.seq = SEQ_IDLE; // [R11]
          st_nxt.filterClear = 1'b1;
        end
        else if (phaseEnd && st_r.cfg[CFG_POWER]) // [R25]
        begin
          dataLoad = 1'b1;
          st_nxt.data = st_r.cfg[CFG_BIPOLAR] ? {~filterData[15], filterData[14:0]} : filterData; // [R9]
          st_nxt.doneFlag = 1'b1; // [R7]
          st_nxt.cfg[CFG_GO] = 1'b0; // [R7]
          if (!st_r.runCont)
            st_nxt.seq = SEQ_IDLE; // [R5]
        end
      end
      SEQ_CAL_OFF:
      begin
        if (phaseEnd && st_r.activeMode == MODE_SELF_BOTH)
        begin
          st_nxt.seq = SEQ_CAL_GAIN; // [R19]
          st_nxt.convNum = 2'h0;
          st_nxt.filterClear = 1'b1;
        end
        else if (phaseEnd)
          calEnd = 1'b1;
      end
      SEQ_CAL_GAIN: calEnd = phaseEnd;
      default: st_nxt.seq = SEQ_IDLE;
    endcase
    if (calEnd)
    begin
      st_nxt.cfg[CFG_MODE_LSB +: 3] = MODE_NORMAL; // [R18]
      st_nxt.cfg[CFG_GO] = 1'b0;
      st_nxt.doneFlag = 1'b1; // [R18]
      st_nxt.seq = SEQ_IDLE; // [R20]
    end
    if (!st_r.cfg[CFG_POWER])
      st_nxt.seq = SEQ_IDLE; // [R6] [R25]
    // Start request
    if (startReq)
    begin
      st_nxt.cfg = newCfg;
      if (newCfg[CFG_POWER])
      begin
        st_nxt.cfg[CFG_GO] = 1'b1;
        st_nxt.seq = firstState(newCfg[CFG_MODE_LSB +: 3]);
        st_nxt.activeMode = newCfg[CFG_MODE_LSB +: 3];
        st_nxt.runCont = newCfg[CFG_CONTINUOUS_EN]; // [R6]
        st_nxt.cycCnt = 32'h0;
        st_nxt.convNum = 2'h0;
        st_nxt.filterClear = 1'b1; // [R2]
      end
      else
        st_nxt.cfg[CFG_GO] = 1'b0; // [R25]
    end
    // Registered outputs
    st_nxt.posOut = st_nxt.cfg[CFG_POWER] ? st_nxt.sel[7:4] : INPUT_OPEN;
    st_nxt.negOut = st_nxt.cfg[CFG_POWER] ? st_nxt.sel[3:0] : INPUT_OPEN;
    st_nxt.readyOut = st_nxt.doneFlag & st_r.maskS2; // [R18]
    st_nxt.busy = st_nxt.seq != SEQ_IDLE;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.csS1 <= 1'b1;
      st_r.csS2 <= 1'b1;
      st_r.doutOeN <= 1'b1;
      st_r.cfg <= CFG_RESET;
      st_r.staged <= CFG_RESET;
      st_r.sel <= MUX_RESET;
      st_r.data <= DATA_RESET;
      st_r.seq <= SEQ_IDLE; // [R20]
      st_r.posOut <= INPUT_OPEN;
      st_r.negOut <= INPUT_OPEN;
    end
    else
      st_r <= st_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dout = st_r.dout;
  assign doutOeN = st_r.doutOeN;
  assign convPowerEn = st_r.cfg[CFG_POWER]; // [R1]
  assign filterClear = st_r.filterClear;
  assign posInputSel = st_r.posOut;
  assign negInputSel = st_r.negOut;
  assign polaritySwap = st_r.cfg[CFG_POLARITY]; // [R10]
  assign bipolarSel = st_r.cfg[CFG_BIPOLAR];
  assign referenceSel = st_r.cfg[CFG_REF]; // [R13]
  assign gainSel = st_r.cfg[CFG_GAIN_LSB +: 2]; // [R14]
  assign rateSel = st_r.cfg[CFG_RATE_LSB +: 3];
  assign calMode = st_r.activeMode;
  assign convBusy = st_r.busy;
  assign convDoneFlag = st_r.doneFlag;
  assign resultReadyOut = st_r.readyOut;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_power_idle: assert property (@(posedge clk) disable iff (!resetn) // [R25]
    !st_r.cfg[CFG_POWER] && !startReq |=> st_r.seq == SEQ_IDLE && $stable(st_r.data))
    else $error("sequencer ran while powered down");
  a_start_clear: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    startReq && newCfg[CFG_POWER] |=> filterClear && st_r.cfg[CFG_GO] && st_r.convNum == 2'h0)
    else $error("start did not clear filter");
  a_first_result: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    dataLoad |-> st_r.convNum == LAST_SETTLE_CYCLE && cycEnd)
    else $error("result before four conversion cycles");
  a_go_self_clear: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    dataLoad && !startReq |=> !st_r.cfg[CFG_GO] && st_r.doneFlag)
    else $error("go bit or done flag wrong after result");
  a_single_stop: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    dataLoad && !st_r.runCont && !startReq |=> st_r.seq == SEQ_IDLE ##1 $stable(st_r.data))
    else $error("single conversion did not stop");
  a_continuous_en_abort: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    st_r.seq == SEQ_CONV && st_r.runCont && !st_r.cfg[CFG_CONTINUOUS_EN] && !startReq
    |=> st_r.seq == SEQ_IDLE && filterClear && $stable(st_r.data))
    else $error("continuous_en clear did not abort");
  a_cal_end: assert property (@(posedge clk) disable iff (!resetn) // [R18]
    calEnd && !startReq |=> st_r.cfg[CFG_MODE_LSB +: 3] == MODE_NORMAL && st_r.doneFlag
    && st_r.seq == SEQ_IDLE)
    else $error("calibration end handling wrong");
  a_combined_order: assert property (@(posedge clk) disable iff (!resetn) // [R19]
    st_r.seq == SEQ_CAL_OFF && phaseEnd && st_r.activeMode == MODE_SELF_BOTH && st_r.cfg[CFG_POWER]
    && !startReq |-> !calEnd ##1 st_r.seq == SEQ_CAL_GAIN)
    else $error("combined calibration order wrong");
  a_staged_hold: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    stagedWrite && !calEnd |=> $stable(st_r.cfg[9:2]) && $stable(st_r.seq))
    else $error("staged write disturbed converter");
  a_open_inputs: assert property (@(posedge clk) disable iff (!resetn) // [R24]
    !st_r.cfg[CFG_POWER] |-> posInputSel == INPUT_OPEN && negInputSel == INPUT_OPEN)
    else $error("inputs not open while powered down");

endmodule

//--- tb/host_model.sv
/*
  Host side of the four-wire serial port: one frame at a time, mode 0, MSB first.
  Assumes clk is the core clock; sclk half period is HALF core clocks.
*/
module host_model #(
  parameter int HALF = 6
)
(
  // Core clock
  input wire logic clk,
  // Serial pins
  output logic csN,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Command byte, then nBits data bits; read bits sampled before each rise
  task automatic frame(input logic [7:0] cmd, input int nBits, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd << (16 - nBits)};
    rd = 16'h0000;
    csN = 1'b0;
    for (int i = 0; i < 8 + nBits; i++)
    begin
      din = sh[23 - i];
      tick(HALF);
      if (i >= 8)
        rd = {rd[14:0], dout};
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
    end
    tick(HALF);
    csN = 1'b1;
    // Released data line no longer holds its value
    din = ~din;
    tick(4);
  endtask
endmodule

//--- tb/sd_adc_ctrl_bench.sv
/*
  Self-checking bench for the converter sequencer: a host model drives frames,
  a reference model predicts registers, outputs, data and timing.
  Assumes conversion cycles shortened through CONV_CYCLES.
*/
module sd_adc_ctrl_bench;
  import sd_adc_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] CC [8] = '{32'h8, 32'h8, 32'h6, 32'h6, 32'h4, 32'h4, 32'h3, 32'h3};
  logic clk, resetn, csN, sclk, din, dout, doutOeN, convDoneMask, convPowerEn, filterClear;
  logic polaritySwap, bipolarSel, referenceSel, convBusy, convDoneFlag, resultReadyOut;
  logic [15:0] filterData, cfgM, stagedM, rd, filt;
  logic [3:0] posInputSel, negInputSel;
  logic [1:0] gainSel;
  logic [2:0] rateSel, calMode;
  logic [7:0] selM;
  int errCount, comparisons, cyc, clrCnt, clrFirst, doneCyc;

  sd_adc_ctrl #(.CONV_CYCLES(CC)) sd_adc_ctrl_i (.clk, .resetn, .csN, .sclk, .din, .dout, .doutOeN,
    .filterData, .convDoneMask, .convPowerEn, .filterClear, .posInputSel, .negInputSel, .polaritySwap,
    .bipolarSel, .referenceSel, .gainSel, .rateSel, .calMode, .convBusy, .convDoneFlag, .resultReadyOut);
  host_model #(.HALF(6)) host_model_i (.clk, .csN, .sclk, .din, .dout);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic testDone();
    $display("comparisons %0d errors %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkCyc(input string what, input int exp, input int got);
    comparisons++;
    if (got < exp - 3 || got > exp + 3)
    begin
      errCount++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic acc(input logic rw, input logic [4:0] a, input logic f, input int n, input logic [15:0] wd);
    host_model_i.frame({1'b1, rw, a, f}, n, wd, rd);
  endtask

  task automatic wrCfg(input logic [15:0] v);
    acc(1'b0, ADDR_CONFIG, 1'b0, 16, v);
    stagedM = v & CFG_WRITE_MASK;
    stagedM[CFG_GO] = 1'b0;
    if (v[CFG_GO])
    begin
      // A go write applies all settings; it starts only when powered
      cfgM = stagedM;
      cfgM[CFG_GO] = v[CFG_POWER];
    end
    else
      {cfgM[CFG_POWER], cfgM[CFG_CONTINUOUS_EN]} = {v[CFG_POWER], v[CFG_CONTINUOUS_EN]};
  endtask

  task automatic chkOut();
    chk("power", 16'(cfgM[CFG_POWER]), 16'(convPowerEn));
    chk("cfgOut", 16'({cfgM[13:12], cfgM[10:5]}), 16'({bipolarSel, polaritySwap, referenceSel, gainSel, rateSel}));
    chk("inputs", 16'(cfgM[CFG_POWER] ? selM : 8'hFF), 16'({posInputSel, negInputSel}));
    chk("oe", 16'h0001, 16'(doutOeN));
  endtask

  task automatic waitDone();
    int i;
    i = 0;
    while (doneCyc < 0 && i < 500)
    begin
      @(posedge clk);
      i++;
    end
    wt(3);
  endtask

  // how: 0 config go, 1 select write with flag, 2 select read with flag
  task automatic conv(input int how, input logic [2:0] m);
    logic [31:0] r;
    logic [7:0] s;
    logic cal;
    int n;
    r = $urandom;
    s = 8'($urandom);
    filt = r[31:16];
    cal = m inside {MODE_SYS_OFFSET, MODE_SYS_GAIN, MODE_SELF_OFFSET, MODE_SELF_GAIN, MODE_SELF_BOTH};
    n = (m == MODE_SELF_BOTH) ? 8 : 4;
    filterData = filt;
    convDoneMask = r[8];
    clrCnt = 0;
    doneCyc = -1;
    wrCfg({1'b1, how == 0, r[1:0], 1'b0, r[2], r[4:3], r[7:5], m, 2'b00});
    if (how > 0)
    begin
      chkOut();
      if (how == 1)
        selM = s;
      acc(how == 2, ADDR_SELECT, 1'b1, 8 * (2 - how), {8'h00, s});
      cfgM = stagedM;
      cfgM[CFG_GO] = 1'b1;
    end
    chkOut();
    chk("calMode", 16'(m), 16'(calMode));
    waitDone();
    chkCyc("convTime", n * int'(CC[cfgM[7:5]]), doneCyc - clrFirst);
    chk("clears", 16'(n / 4), 16'(clrCnt));
    chk("busy", 16'h0000, 16'(convBusy));
    chk("ready", 16'(convDoneMask), 16'(resultReadyOut));
    cfgM[CFG_GO] = 1'b0;
    if (cal)
      cfgM[4:2] = MODE_NORMAL;
    acc(1'b1, ADDR_CONFIG, 1'b0, 16, 16'h0000);
    chk("cfgRead", cfgM & CFG_WRITE_MASK, rd);
    acc(1'b1, ADDR_DATA, 1'b0, 16, 16'h0000);
    if (!cal)
      chk("data", filt ^ {cfgM[CFG_BIPOLAR], 15'h0000}, rd);
    chk("doneClr", 16'h0000, 16'(convDoneFlag));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (filterClear)
    begin
      if (clrCnt == 0)
        clrFirst <= cyc;
      clrCnt <= clrCnt + 1;
    end
    if (convDoneFlag && doneCyc < 0)
      doneCyc <= cyc;
    if (cyc == 40000)
    begin
      errCount++;
      testDone();
    end
  end

  initial
  begin
    resetn = 1'b0;
    filterData = 16'h0000;
    convDoneMask = 1'b0;
    cfgM = CFG_RESET;
    stagedM = CFG_RESET;
    selM = MUX_RESET;
    doneCyc = -1;
    wt(20);
    resetn = 1'b1;
    wt(4);
    void'($urandom(32'h9A260432));
    chkOut();
    acc(1'b1, ADDR_CONFIG, 1'b0, 16, 16'h0000);
    chk("cfgReset", CFG_RESET, rd);
    acc(1'b1, ADDR_DATA, 1'b0, 16, 16'h0000);
    chk("dataReset", DATA_RESET, rd);
    // Each offset mode comes before its gain mode in this order
    for (int m = 0; m < 8; m++)
      conv(m % 3, 3'(m));
    // Continuous run, then abort, continuous_en alone, power off
    filt = 16'($urandom);
    filterData = filt;
    clrCnt = 0;
    doneCyc = -1;
    wrCfg(16'hC8E0);
    waitDone();
    chkCyc("contFirst", 4 * int'(CC[7]), doneCyc - clrFirst);
    acc(1'b1, ADDR_DATA, 1'b0, 16, 16'h0000);
    chk("contData", filt, rd);
    wt(2 * int'(CC[7]) + 5);
    chk("contAgain", 16'h0001, 16'(convDoneFlag));
    selM = 8'($urandom);
    acc(1'b0, ADDR_SELECT, 1'b0, 8, {8'h00, selM});
    chkOut();
    chk("busyRun", 16'h0001, 16'(convBusy));
    clrCnt = 0;
    wrCfg(16'h8000);
    wt(4);
    chk("stopBusy", 16'h0000, 16'(convBusy));
    chk("stopClear", 16'h0001, 16'(clrCnt));
    acc(1'b1, ADDR_DATA, 1'b0, 16, 16'h0000);
    chk("stopData", filt, rd);
    wrCfg(16'h8800);
    wt(4 * int'(CC[0]) + 10);
    chk("contOnly", 16'h0000, 16'(convBusy));
    wrCfg(16'h4000);
    chkOut();
    wt(4 * int'(CC[0]) + 10);
    chk("offBusy", 16'h0000, 16'({convBusy, convDoneFlag}));
    acc(1'b1, ADDR_DATA, 1'b0, 16, 16'h0000);
    chk("offData", filt, rd);
    testDone();
  end
endmodule
